/* File: common/trd_edge_if.sv */
// Carrier for a synchronised level and its rising edge.
// Assumes both ends sit on the reference clock.
`timescale 1ns/1ns
`default_nettype none

interface trd_edge_if;
    logic lvl;
    logic rise;
    modport src (output lvl, output rise);
    modport dst (input lvl, input rise);
endinterface : trd_edge_if

`default_nettype wire

/* File: common/trd_pkg.sv */
// Constants and types of the timing reference divider.
// Assumes a single 50 MHz reference clock samples every pin.
//
// Functional notes
// RULE1 - One-second pulse, one rx line clock wide
// RULE2 - Timer runs from channel one after reset
// RULE3 - Lost channel N clock uses channel N+1
// RULE4 - Each channel retimes pulse to own clock
// RULE5 - Highway clock is 2.048, 4.096 or 8.192 MHz
// RULE6 - Frame sync 8 kHz, width one clock to 50%
// RULE7 - Divided tx framer clock at 32 or 8 kHz
// RULE8 - Divided rx clock 8 kHz, channel selectable
// RULE9 - Divided highway clock at 8 kHz
// RULE10 - Phase error: divided highway versus divided rx
// RULE11 - Phase error: divided tx versus divided highway
// RULE12 - Strap high DS1, strap low CEPT
// RULE13 - Reset clears all; strap picks mode after
// RULE14 - Tx clock loss after 250 us, release 250 us
// RULE15 - Timer counts nominal line rate per second
// RULE16 - Dividers are synchronous, near 50% duty
`default_nettype none

package trd_pkg;
    // ********************************
    // Pin bundle positions
    // ********************************
    localparam int NCH = 8;
    localparam int SEL_W = 3;
    localparam int SYNC_N = 34;
    localparam int RX_BASE = 0;
    localparam int LOSS_BASE = 8;
    localparam int STRAP_BASE = 16;
    localparam int TX_BIT = 24;
    localparam int HW_BIT = 25;
    localparam int FS_BIT = 26;
    localparam int GSEL_BASE = 27;
    localparam int TX32_BIT = 30;
    localparam int TXHI_BIT = 31;
    localparam int HWR_BASE = 32;
    // ********************************
    // Divider ratios
    // ********************************
    localparam int DIV_W = 11;
    localparam logic [DIV_W-1:0] DIV_DS1_8K = 11'h0c1;
    localparam logic [DIV_W-1:0] DIV_DS1_HI_8K = 11'h304;
    localparam logic [DIV_W-1:0] DIV_2M_8K = 11'h100;
    localparam logic [DIV_W-1:0] DIV_4M_8K = 11'h200;
    localparam logic [DIV_W-1:0] DIV_8M_8K = 11'h400;
    localparam logic [DIV_W-1:0] DIV_DS1_32K = 11'h030;
    localparam logic [DIV_W-1:0] DIV_2M_32K = 11'h040;
    localparam logic [DIV_W-1:0] DIV_RST = 11'h000;
    // ********************************
    // Timing
    // ********************************
    localparam int REF_PERIOD_NS = 20;
    localparam int LOSS_TIME_NS = 250000;
    localparam int LOSS_CYCLES_DFLT = LOSS_TIME_NS / REF_PERIOD_NS;
    localparam int LOSS_W = 14;
    localparam int SEC_W = 21;
    localparam int SEC_DS1_CYCLES_DFLT = 1544000;
    localparam int SEC_CEPT_CYCLES_DFLT = 2048000;
    localparam logic [1:0] STRAP_CAPT = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;
    typedef enum logic [2:0] {
        TL_OK = 3'h1,
        TL_LOST = 3'h2,
        TL_REC = 3'h4
    } trd_loss_st_t;
endpackage : trd_pkg

`default_nettype wire

/* File: hw/trd_div.sv */
// Edge-counting clock divider, high for the first half.
// Assumes ratio of at least two, steady between edges.
`timescale 1ns/1ns
`default_nettype none

module trd_div (
    input wire logic clk_in,
    input wire logic nrst_in,
    trd_edge_if.dst src_if,
    input wire logic [trd_pkg::DIV_W-1:0] ratio_in,
    input wire logic align_in,
    output logic div_out
);
    import trd_pkg::*;

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic div_d;

    always_comb begin
        cnt_d = cnt_q;
        if (align_in) begin
            cnt_d = DIV_RST;
        end else if (src_if.rise) begin
            // Odd ratios give a duty a half count off 50%
            if (cnt_q >= ratio_in - 11'h001) begin // RULE16
                cnt_d = DIV_RST;
            end else begin
                cnt_d = cnt_q + 11'h001;
            end
        end
        div_d = (cnt_d < (ratio_in >> 1)); // RULE16
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= DIV_RST;
            div_out <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            div_out <= div_d;
        end
    end
endmodule : trd_div

`default_nettype wire

/* File: hw/trd_sync.sv */
// Two-flop synchroniser with rising-edge detect.
// Assumes the input is slower than half the reference clock.
`timescale 1ns/1ns
`default_nettype none

module trd_sync (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic raw_in,
    trd_edge_if.src edge_if
);
    logic [2:0] s_q;
    logic [2:0] s_d;

    always_comb begin
        s_d = {s_q[1:0], raw_in};
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= 3'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // First stage feeds only the second
    assign edge_if.lvl = s_q[1];
    assign edge_if.rise = s_q[1] & ~s_q[2];
endmodule : trd_sync

`default_nettype wire

/* File: hw/trd_top.sv */
// Timing reference divider: second timer, dividers,
// phase detectors, tx clock loss and line-standard straps.
// Assumes every pin is asynchronous to REF_CLK_IN and all
// incoming clocks run below a third of its rate.
`timescale 1ns/1ns
`default_nettype none

module trd_top #(
    parameter int LOSS_CYCLES = trd_pkg::LOSS_CYCLES_DFLT,
    parameter int SEC_DS1_CYCLES = trd_pkg::SEC_DS1_CYCLES_DFLT,
    parameter int SEC_CEPT_CYCLES = trd_pkg::SEC_CEPT_CYCLES_DFLT
) (
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    input wire logic [trd_pkg::NCH-1:0] RX_LINE_CLOCK_IN,
    input wire logic [trd_pkg::NCH-1:0] RX_LINE_CLOCK_LOSS_IN,
    input wire logic [trd_pkg::NCH-1:0] LINE_STANDARD_STRAP_IN,
    input wire logic TX_FRAMER_CLOCK_IN,
    input wire logic HIGHWAY_CLOCK_IN,
    input wire logic HIGHWAY_FRAME_SYNC_IN,
    input wire logic [trd_pkg::SEL_W-1:0] GLOBAL_CLOCK_SELECT_CONTROL_IN,
    input wire logic TX_DIV_32K_IN,
    input wire logic TX_CLOCK_HIGH_IN,
    input wire logic [1:0] HIGHWAY_RATE_IN,
    output logic SECOND_PULSE_OUT,
    output logic [trd_pkg::NCH-1:0] CHANNEL_SECOND_OUT,
    output logic [trd_pkg::NCH-1:0] CHANNEL_DS1_MODE_OUT,
    output logic TX_CLOCK_DIVIDED_OUT,
    output logic RX_CLOCK_DIVIDED_OUT,
    output logic HIGHWAY_CLOCK_DIVIDED_OUT,
    output logic HIGHWAY_PHASE_ERROR_OUT,
    output logic TX_CLOCK_PHASE_ERROR_OUT,
    output logic TX_FRAMER_CLOCK_LOSS_OUT
);
    import trd_pkg::*;

    localparam logic [LOSS_W-1:0] LOSS_LAST = LOSS_W'(LOSS_CYCLES - 1);
    localparam logic [SEC_W-1:0] SEC_DS1_LAST = SEC_W'(SEC_DS1_CYCLES - 1);
    localparam logic [SEC_W-1:0] SEC_CEPT_LAST = SEC_W'(SEC_CEPT_CYCLES - 1);

    // ********************************
    // Pin synchronisers
    // ********************************
    logic [SYNC_N-1:0] raw;
    logic [SYNC_N-1:0] lvl;
    logic [SYNC_N-1:0] rise;

    assign raw = {HIGHWAY_RATE_IN, TX_CLOCK_HIGH_IN, TX_DIV_32K_IN,
        GLOBAL_CLOCK_SELECT_CONTROL_IN, HIGHWAY_FRAME_SYNC_IN,
        HIGHWAY_CLOCK_IN, TX_FRAMER_CLOCK_IN, LINE_STANDARD_STRAP_IN,
        RX_LINE_CLOCK_LOSS_IN, RX_LINE_CLOCK_IN};

    trd_edge_if sync_if [SYNC_N] ();

    for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
        trd_sync u_sync (
            .clk_in(REF_CLK_IN),
            .nrst_in(NRST_IN),
            .raw_in(raw[i]),
            .edge_if(sync_if[i])
        );
        assign lvl[i] = sync_if[i].lvl;
        assign rise[i] = sync_if[i].rise;
    end

    logic [NCH-1:0] rx_rise;
    logic [NCH-1:0] loss_lvl;
    logic [NCH-1:0] strap_lvl;
    logic [SEL_W-1:0] gsel;
    logic [1:0] hw_rate;
    logic tx_rise;

    assign rx_rise = rise[RX_BASE +: NCH];
    assign loss_lvl = lvl[LOSS_BASE +: NCH];
    assign strap_lvl = lvl[STRAP_BASE +: NCH];
    assign gsel = lvl[GSEL_BASE +: SEL_W];
    assign hw_rate = lvl[HWR_BASE +: 2];
    assign tx_rise = rise[TX_BIT];

    // ********************************
    // Line-standard straps
    // ********************************
    // Strap is caught once the synchroniser has settled
    logic [1:0] st_q;
    logic [1:0] st_d;
    logic [NCH-1:0] ds1_d;

    always_comb begin
        st_d = st_q;
        ds1_d = CHANNEL_DS1_MODE_OUT;
        if (st_q != STRAP_DONE) begin
            st_d = st_q + 2'h1;
        end
        if (st_q == STRAP_CAPT) begin
            ds1_d = strap_lvl; // RULE12 RULE13
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            st_q <= 2'h0; // RULE13
            CHANNEL_DS1_MODE_OUT <= 8'h00;
        end else begin
            st_q <= st_d;
            CHANNEL_DS1_MODE_OUT <= ds1_d;
        end
    end

    // ********************************
    // One-second timer
    // ********************************
    logic [SEL_W-1:0] sel_idx;
    logic sel_found;
    logic sel_rise;
    logic [SEC_W-1:0] sec_last;
    logic [SEC_W-1:0] sec_cnt_q;
    logic [SEC_W-1:0] sec_cnt_d;
    logic sec_d;
    logic [NCH-1:0] ch_sec_d;

    // First channel whose clock is present; all lost keeps one
    always_comb begin
        sel_idx = 3'h0; // RULE2
        sel_found = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if (!sel_found && !loss_lvl[i]) begin
                sel_idx = SEL_W'(i); // RULE3
                sel_found = 1'b1;
            end
        end
    end

    assign sel_rise = rx_rise[sel_idx];
    assign sec_last = CHANNEL_DS1_MODE_OUT[sel_idx] ? SEC_DS1_LAST : SEC_CEPT_LAST;

    // Count survives a source switch so the second is not restarted
    always_comb begin
        sec_cnt_d = sec_cnt_q;
        sec_d = SECOND_PULSE_OUT;
        if (sel_rise) begin
            if (sec_cnt_q >= sec_last) begin
                sec_cnt_d = 21'h000000; // RULE15
                sec_d = 1'b1; // RULE1
            end else begin
                sec_cnt_d = sec_cnt_q + 21'h000001;
                sec_d = 1'b0; // RULE1
            end
        end
        for (int i = 0; i < NCH; i++) begin
            ch_sec_d[i] = rx_rise[i] ? SECOND_PULSE_OUT : CHANNEL_SECOND_OUT[i]; // RULE4
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            sec_cnt_q <= 21'h000000;
            SECOND_PULSE_OUT <= 1'b0;
            CHANNEL_SECOND_OUT <= 8'h00;
        end else begin
            sec_cnt_q <= sec_cnt_d;
            SECOND_PULSE_OUT <= sec_d;
            CHANNEL_SECOND_OUT <= ch_sec_d;
        end
    end

    // ********************************
    // Divided clocks
    // ********************************
    logic [DIV_W-1:0] tx_ratio;
    logic [DIV_W-1:0] rx_ratio;
    logic [DIV_W-1:0] hw_ratio;
    trd_edge_if rx_sel_if ();

    assign rx_sel_if.lvl = lvl[RX_BASE + gsel];
    assign rx_sel_if.rise = rx_rise[gsel]; // RULE8

    // DS1 low rate at 32 kHz is not a whole ratio; 48 is nearest
    always_comb begin
        case ({lvl[TX32_BIT], lvl[TXHI_BIT], CHANNEL_DS1_MODE_OUT[0]})
            3'h0: tx_ratio = DIV_2M_8K;
            3'h1: tx_ratio = DIV_DS1_8K;
            3'h2: tx_ratio = DIV_8M_8K;
            3'h3: tx_ratio = DIV_DS1_HI_8K;
            3'h4: tx_ratio = DIV_2M_32K;
            3'h5: tx_ratio = DIV_DS1_32K;
            3'h6: tx_ratio = DIV_2M_8K;
            default: tx_ratio = DIV_DS1_8K;
        endcase
        rx_ratio = CHANNEL_DS1_MODE_OUT[gsel] ? DIV_DS1_8K : DIV_2M_8K; // RULE8
        if (hw_rate == 2'h0) begin
            hw_ratio = DIV_2M_8K; // RULE5
        end else if (hw_rate == 2'h1) begin
            hw_ratio = DIV_4M_8K;
        end else begin
            hw_ratio = DIV_8M_8K;
        end
    end

    trd_div u_tx_div (
        .clk_in(REF_CLK_IN),
        .nrst_in(NRST_IN),
        .src_if(sync_if[TX_BIT]),
        .ratio_in(tx_ratio),
        .align_in(1'b0),
        .div_out(TX_CLOCK_DIVIDED_OUT) // RULE7
    );

    trd_div u_rx_div (
        .clk_in(REF_CLK_IN),
        .nrst_in(NRST_IN),
        .src_if(rx_sel_if),
        .ratio_in(rx_ratio),
        .align_in(1'b0),
        .div_out(RX_CLOCK_DIVIDED_OUT) // RULE8
    );

    // Frame sync edge realigns the highway divider
    trd_div u_hw_div (
        .clk_in(REF_CLK_IN),
        .nrst_in(NRST_IN),
        .src_if(sync_if[HW_BIT]),
        .ratio_in(hw_ratio),
        .align_in(rise[FS_BIT]), // RULE6
        .div_out(HIGHWAY_CLOCK_DIVIDED_OUT) // RULE9
    );

    // ********************************
    // Phase detectors
    // ********************************
    // XOR detector: duty tracks phase, filtering is off chip
    logic hpe_d;
    logic tpe_d;

    always_comb begin
        hpe_d = HIGHWAY_CLOCK_DIVIDED_OUT ^ RX_CLOCK_DIVIDED_OUT; // RULE10
        tpe_d = TX_CLOCK_DIVIDED_OUT ^ HIGHWAY_CLOCK_DIVIDED_OUT; // RULE11
    end

    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            HIGHWAY_PHASE_ERROR_OUT <= 1'b0;
            TX_CLOCK_PHASE_ERROR_OUT <= 1'b0;
        end else begin
            HIGHWAY_PHASE_ERROR_OUT <= hpe_d;
            TX_CLOCK_PHASE_ERROR_OUT <= tpe_d;
        end
    end

    // ********************************
    // Tx framer clock loss
    // ********************************
    trd_loss_st_t tl_q;
    trd_loss_st_t tl_d;
    logic [LOSS_W-1:0] tl_cnt_q;
    logic [LOSS_W-1:0] tl_cnt_d;
    logic loss_d;

    always_comb begin
        tl_d = tl_q;
        tl_cnt_d = tl_cnt_q + 14'h0001;
        case (tl_q)
            TL_OK: begin
                if (tx_rise) begin
                    tl_cnt_d = 14'h0000;
                end else if (tl_cnt_q == LOSS_LAST) begin
                    tl_d = TL_LOST; // RULE14
                    tl_cnt_d = 14'h0000;
                end
            end
            TL_LOST: begin
                tl_cnt_d = 14'h0000;
                if (tx_rise) begin
                    tl_d = TL_REC;
                end
            end
            TL_REC: begin
                // Release is timed from the first edge only
                if (tl_cnt_q == LOSS_LAST) begin
                    tl_d = TL_OK; // RULE14
                    tl_cnt_d = 14'h0000;
                end
            end
            default: begin
                tl_d = TL_OK;
                tl_cnt_d = 14'h0000;
            end
        endcase
        loss_d = (tl_d != TL_OK);
    end

    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            tl_q <= TL_OK;
            tl_cnt_q <= 14'h0000;
            TX_FRAMER_CLOCK_LOSS_OUT <= 1'b0;
        end else begin
            tl_q <= tl_d;
            tl_cnt_q <= tl_cnt_d;
            TX_FRAMER_CLOCK_LOSS_OUT <= loss_d;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!NRST_IN);

    a_sec_pulse_hold: assert property ( // RULE1
        SECOND_PULSE_OUT && !sel_rise |=> SECOND_PULSE_OUT)
        else $error("second pulse dropped early");
    a_sec_pulse_end: assert property ( // RULE1
        SECOND_PULSE_OUT && sel_rise |=> !SECOND_PULSE_OUT)
        else $error("second pulse longer than one cycle");
    a_sec_default_src: assert property ( // RULE2
        !loss_lvl[0] |-> sel_idx == 3'h0)
        else $error("timer not on channel one");
    a_sec_fail_over: assert property ( // RULE3
        loss_lvl[0] && !loss_lvl[1] |-> sel_idx == 3'h1)
        else $error("timer did not move to next channel");
    a_chan_retime: assert property ( // RULE4
        rx_rise[0] |=> CHANNEL_SECOND_OUT[0] == $past(SECOND_PULSE_OUT))
        else $error("channel pulse not retimed");
    a_sec_count_wrap: assert property ( // RULE15
        sel_rise && sec_cnt_q == sec_last |=> SECOND_PULSE_OUT && sec_cnt_q == 21'h000000)
        else $error("second not issued at terminal count");
    a_sec_count_quiet: assert property ( // RULE15
        sel_rise && sec_cnt_q < sec_last |=> !SECOND_PULSE_OUT)
        else $error("second issued early");
    a_loss_set: assert property ( // RULE14
        tl_q == TL_OK && tl_cnt_q == LOSS_LAST && !tx_rise |=> TX_FRAMER_CLOCK_LOSS_OUT)
        else $error("tx clock loss not raised");
    a_loss_release: assert property ( // RULE14
        tl_q == TL_REC && tl_cnt_q == LOSS_LAST |=> !TX_FRAMER_CLOCK_LOSS_OUT)
        else $error("tx clock loss not released");
    a_hw_phase_err: assert property ( // RULE10
        1'b1 |=> HIGHWAY_PHASE_ERROR_OUT
            == ($past(HIGHWAY_CLOCK_DIVIDED_OUT) ^ $past(RX_CLOCK_DIVIDED_OUT)))
        else $error("highway phase error wrong");
    a_tx_phase_err: assert property ( // RULE11
        1'b1 |=> TX_CLOCK_PHASE_ERROR_OUT
            == ($past(TX_CLOCK_DIVIDED_OUT) ^ $past(HIGHWAY_CLOCK_DIVIDED_OUT)))
        else $error("tx phase error wrong");
    a_strap_capture: assert property ( // RULE12
        st_q == STRAP_CAPT |=> CHANNEL_DS1_MODE_OUT == $past(strap_lvl))
        else $error("strap not captured");
    a_mode_stable: assert property ( // RULE13
        st_q == STRAP_DONE |=> $stable(CHANNEL_DS1_MODE_OUT))
        else $error("mode changed after capture");

    c_second_pulse: cover property ($rose(SECOND_PULSE_OUT));
    c_fail_over: cover property (loss_lvl[0] && sel_rise);
    c_tx_loss: cover property ($rose(TX_FRAMER_CLOCK_LOSS_OUT));
    c_tx_recover: cover property ($fell(TX_FRAMER_CLOCK_LOSS_OUT));
endmodule : trd_top

`default_nettype wire

/* File: verification/trd_highway_partner.sv */
// Behavioural model of the system highway timing source.
// Assumes the bench drives its rate pin; it has no reset.
`timescale 1ns/1ns
`default_nettype none

module trd_highway_partner (
    input wire logic [1:0] rate_in,
    output logic hw_clk_out,
    output logic fs_out
);
    int half_ns;
    int frame_len;
    int bit_cnt;
    // ********************************
    // Clock and frame sync
    // ********************************
    // Time scaled down, 4:2:1 kept; edges fall clear of the bench sampling edge
    initial begin
        hw_clk_out = 1'b0;
        fs_out = 1'b0;
        bit_cnt = 0;
        #5;
        forever begin
            half_ns = (rate_in == 2'h0) ? 160 : (rate_in == 2'h1) ? 80 : 40;
            frame_len = (rate_in == 2'h0) ? 256 : (rate_in == 2'h1) ? 512 : 1024;
            #half_ns;
            hw_clk_out = 1'b1;
            fs_out = (bit_cnt == 0);
            bit_cnt = (bit_cnt + 1 >= frame_len) ? 0 : bit_cnt + 1;
            #half_ns;
            hw_clk_out = 1'b0;
        end
    end
endmodule : trd_highway_partner

`default_nettype wire

/* File: verification/trd_top_tb_top.sv */
// Self-checking bench of the timing reference divider.
// Assumes shortened second and loss counts; rx and tx pin clocks made here.
`timescale 1ns/1ns
`default_nettype none

module trd_top_tb_top;
    import trd_pkg::*;
    localparam int LOSS_N = 20;
    localparam int SEC_DS1_N = 10;
    localparam int SEC_CEPT_N = 12;
    logic ref_clk;
    logic nrst;
    logic [NCH-1:0] rx_clk, rx_loss, strap, rx_run, ch_sec, ch_ds1;
    logic tx_clk, tx_run, tx32, txhi, hw_clk, hw_fs;
    logic [SEL_W-1:0] gsel;
    logic [1:0] hw_rate;
    logic sec, tx_div, rx_div, hw_div, hw_err, tx_err, tx_loss;
    int err_total;
    int cmp_count;
    int tx_tab[4] = '{193, 772, 48, 193};

    trd_top #(.LOSS_CYCLES(LOSS_N), .SEC_DS1_CYCLES(SEC_DS1_N), .SEC_CEPT_CYCLES(SEC_CEPT_N))
        trd_top_inst (.REF_CLK_IN(ref_clk), .NRST_IN(nrst), .RX_LINE_CLOCK_IN(rx_clk),
        .RX_LINE_CLOCK_LOSS_IN(rx_loss), .LINE_STANDARD_STRAP_IN(strap),
        .TX_FRAMER_CLOCK_IN(tx_clk), .HIGHWAY_CLOCK_IN(hw_clk), .HIGHWAY_FRAME_SYNC_IN(hw_fs),
        .GLOBAL_CLOCK_SELECT_CONTROL_IN(gsel), .TX_DIV_32K_IN(tx32), .TX_CLOCK_HIGH_IN(txhi),
        .HIGHWAY_RATE_IN(hw_rate), .SECOND_PULSE_OUT(sec), .CHANNEL_SECOND_OUT(ch_sec),
        .CHANNEL_DS1_MODE_OUT(ch_ds1), .TX_CLOCK_DIVIDED_OUT(tx_div),
        .RX_CLOCK_DIVIDED_OUT(rx_div), .HIGHWAY_CLOCK_DIVIDED_OUT(hw_div),
        .HIGHWAY_PHASE_ERROR_OUT(hw_err), .TX_CLOCK_PHASE_ERROR_OUT(tx_err),
        .TX_FRAMER_CLOCK_LOSS_OUT(tx_loss));

    trd_highway_partner trd_highway_partner_inst (.rate_in(hw_rate), .hw_clk_out(hw_clk),
        .fs_out(hw_fs));

    // ********************************
    // Clocks
    // ********************************
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;
    // Pin clocks held low when stopped, never left floating
    for (genvar g = 0; g < NCH; g++) begin : g_rx
        initial begin
            rx_clk[g] = 1'b0;
            #5;
            forever begin
                #(40 + 10 * g);
                rx_clk[g] = rx_run[g] & ~rx_clk[g];
            end
        end
    end
    initial begin
        tx_clk = 1'b0;
        #5;
        forever begin
            #40;
            tx_clk = tx_run & ~tx_clk;
        end
    end

    // ********************************
    // Shared tasks
    // ********************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    function automatic logic pick_div(input int d);
        return (d == 0) ? tx_div : (d == 1) ? rx_div : (d == 2) ? hw_div : sec;
    endfunction : pick_div

    function automatic logic pick_src(input int s);
        return (s < NCH) ? rx_clk[s] : (s == NCH) ? tx_clk : hw_clk;
    endfunction : pick_src

    // Source rises over one output period; early periods skipped as they may be cut short
    task automatic measure(input int d, input int s, input int skip, output int n);
        logic pd, ps;
        int rises;
        int guard;
        pd = pick_div(d);
        ps = pick_src(s);
        rises = 0;
        guard = 0;
        n = 0;
        while (rises <= skip && guard < 20000) begin
            @(negedge ref_clk);
            guard++;
            if (rises == skip && ps === 1'b0 && pick_src(s) === 1'b1) begin
                n++;
            end
            if (pd === 1'b0 && pick_div(d) === 1'b1) begin
                rises++;
            end
            pd = pick_div(d);
            ps = pick_src(s);
        end
        if (guard >= 20000) begin
            $display("mismatch at %0t: output never toggled", $time);
            err_total++;
            print_verdict();
        end
    endtask : measure

    task automatic do_reset();
        @(negedge ref_clk);
        nrst = 1'b0;
        repeat (20) @(negedge ref_clk);
        check({sec, ch_ds1, tx_loss}, 32'h0, "outputs in reset");
        nrst = 1'b1;
    endtask : do_reset

    // ********************************
    // Scenarios
    // ********************************
    task automatic test_strap();
        strap = 8'h5a;
        do_reset();
        repeat (6) @(negedge ref_clk);
        check(ch_ds1, 8'h5a, "strap mode");
        strap = 8'ha5;
        repeat (6) @(negedge ref_clk);
        check(ch_ds1, 8'h5a, "mode frozen");
        do_reset();
        repeat (6) @(negedge ref_clk);
        check(ch_ds1, 8'ha5, "mode after reset");
        $display("test strap done");
    endtask : test_strap

    task automatic test_second();
        int n;
        int w;
        int guard;
        logic ps;
        measure(3, 0, 1, n);
        check(n, SEC_DS1_N, "second period");
        w = 0;
        guard = 0;
        ps = rx_clk[0];
        while (sec === 1'b1 && guard < 100) begin
            @(negedge ref_clk);
            w += (!ps && rx_clk[0]) ? 1 : 0;
            ps = rx_clk[0];
            guard++;
        end
        check(w, 1, "second width");
        $display("test second done");
    endtask : test_second

    task automatic test_loss_switch();
        int n;
        // Channel one must retime the fallen second before it stops
        repeat (8) @(negedge ref_clk);
        rx_run[0] = 1'b0;
        rx_loss[0] = 1'b1;
        measure(3, 1, 2, n);
        check(n, SEC_CEPT_N, "second from channel two");
        repeat (6) @(negedge ref_clk);
        check(ch_sec[1], 1'b1, "retimed on channel two");
        check(ch_sec[0], 1'b0, "stopped channel quiet");
        rx_run[1] = 1'b0;
        rx_loss[1] = 1'b1;
        measure(3, 2, 2, n);
        check(n, SEC_DS1_N, "second from channel three");
        rx_run = '1;
        rx_loss = '0;
        $display("test loss switch done");
    endtask : test_loss_switch

    task automatic test_dividers();
        int n;
        int bad_hw;
        int bad_tx;
        logic xh_q, xt_q;
        for (int r = 0; r < 4; r++) begin
            hw_rate = r[1:0];
            measure(2, 9, 2, n);
            check(n, 256 << ((r > 2) ? 2 : r), "highway ratio");
        end
        gsel = 3'h0;
        measure(1, 0, 2, n);
        check(n, 193, "rx ratio ds1");
        gsel = 3'h1;
        measure(1, 1, 2, n);
        check(n, 256, "rx ratio cept");
        for (int k = 0; k < 4; k++) begin
            {tx32, txhi} = k[1:0];
            measure(0, 8, 2, n);
            check(n, tx_tab[k], "tx ratio");
        end
        // Detector output lags its inputs by one register
        bad_hw = 0;
        bad_tx = 0;
        xh_q = hw_div ^ rx_div;
        xt_q = tx_div ^ hw_div;
        repeat (4000) begin
            @(negedge ref_clk);
            bad_hw += (hw_err !== xh_q) ? 1 : 0;
            bad_tx += (tx_err !== xt_q) ? 1 : 0;
            xh_q = hw_div ^ rx_div;
            xt_q = tx_div ^ hw_div;
        end
        check(bad_hw, 0, "highway phase error");
        check(bad_tx, 0, "tx phase error");
        $display("test dividers done");
    endtask : test_dividers

    task automatic test_tx_loss();
        check(tx_loss, 1'b0, "loss while running");
        @(posedge tx_clk);
        tx_run = 1'b0;
        repeat (16) @(negedge ref_clk);
        check(tx_loss, 1'b0, "loss too early");
        repeat (16) @(negedge ref_clk);
        check(tx_loss, 1'b1, "loss raised");
        tx_run = 1'b1;
        @(posedge tx_clk);
        repeat (10) @(negedge ref_clk);
        check(tx_loss, 1'b1, "loss held after edge");
        repeat (25) @(negedge ref_clk);
        check(tx_loss, 1'b0, "loss released");
        $display("test tx loss done");
    endtask : test_tx_loss

    // ********************************
    // Main sequence and watchdog
    // ********************************
    initial begin
        err_total = 0;
        cmp_count = 0;
        nrst = 1'b0;
        strap = 8'h5a;
        rx_run = '1;
        rx_loss = '0;
        tx_run = 1'b1;
        tx32 = 1'b0;
        txhi = 1'b0;
        gsel = 3'h0;
        hw_rate = 2'h0;
        test_strap();
        test_second();
        test_loss_switch();
        test_dividers();
        test_tx_loss();
        print_verdict();
    end

    initial begin
        #2000000;
        $display("mismatch at %0t: watchdog expired", $time);
        err_total++;
        print_verdict();
    end
endmodule : trd_top_tb_top

`default_nettype wire
